// ### core/chbd_pkg.sv
// shared constants and types for the card host port
package chbd_pkg;
  // ==========================================================
  // widths and decode
  localparam int CHBD_DW = 16;
  localparam int CHBD_AW = 3;
  localparam logic [2:0] CHBD_DATA_REG = 3'h0;
  localparam logic [1:0] CHBD_LANE_LO = 2'h1;
  localparam logic [1:0] CHBD_LANE_ALL = 2'h3;
  // ==========================================================
  // timing, 50 MHz clock
  localparam int CHBD_CLK_NS = 20;
  localparam int CHBD_T_SETUP_NS = 60;
  localparam int CHBD_T_STROBE_NS = 300;
  localparam int CHBD_SETUP_CYC = (CHBD_T_SETUP_NS + CHBD_CLK_NS - 1) / CHBD_CLK_NS;
  localparam int CHBD_STROBE_CYC = (CHBD_T_STROBE_NS + CHBD_CLK_NS - 1) / CHBD_CLK_NS;
  localparam int CHBD_CNT_W = 5;
  // ==========================================================
  // reset values of pin synchronisers
  localparam logic [24:0] CHBD_DEV_SYNC_RST = 25'h1F0_0001;
  localparam logic [18:0] CHBD_HOST_SYNC_RST = 19'h2_0001;
  // ==========================================================
  // modes and host commands
  typedef enum logic [1:0] {CHBD_MODE_MEM, CHBD_MODE_IO, CHBD_MODE_IDE} chbd_mode_e;
  typedef enum logic [2:0] {
    CHBD_CMD_REG_RD, CHBD_CMD_REG_WR, CHBD_CMD_DAT_RD, CHBD_CMD_DAT_WR,
    CHBD_CMD_DMA_RD, CHBD_CMD_DMA_WR
  } chbd_cmd_e;
endpackage : chbd_pkg

// ### core/chbd_if.sv
// pin bundle between card and host controller
interface chbd_if;
  import chbd_pkg::*;
  // host driven
  chbd_mode_e mode;
  logic [2:0] addr;
  logic cs0_n;
  logic cs1_n;
  logic iord_n;
  logic iowr_n;
  logic dmack_n;
  logic [15:0] host_d_o;
  logic [1:0] host_d_oe;
  // device driven
  logic [15:0] dev_d_o;
  logic [1:0] dev_d_oe;
  logic inpack_n;
  logic dmarq_o;
  logic dmarq_oe;
  logic dasp_oe;
  // resolved wire levels, pull-ups on data and activity, pull-down on request
  logic [15:0] d;
  logic dmarq;
  logic dasp_n;
  assign d[7:0] = dev_d_oe[0] ? dev_d_o[7:0] : (host_d_oe[0] ? host_d_o[7:0] : 8'hFF);
  assign d[15:8] = dev_d_oe[1] ? dev_d_o[15:8] : (host_d_oe[1] ? host_d_o[15:8] : 8'hFF);
  assign dmarq = dmarq_oe ? dmarq_o : 1'b0;
  assign dasp_n = dasp_oe ? 1'b0 : 1'b1;
  modport dev (
    input mode, addr, cs0_n, cs1_n, iord_n, iowr_n, dmack_n, d, dasp_n,
    output dev_d_o, dev_d_oe, inpack_n, dmarq_o, dmarq_oe, dasp_oe
  );
  modport host (
    input d, inpack_n, dmarq, dasp_n,
    output mode, addr, cs0_n, cs1_n, iord_n, iowr_n, dmack_n, host_d_o, host_d_oe
  );
endinterface : chbd_if

// ### core/chbd_dev.sv
// card end of the host port: task file, data word, input ack, dma request
// ==========================================================
// Notes on behaviour
// - activity line shared between two attached devices
// - bit 0 even byte, bit 8 odd byte
// - task file on low lane, data full word
// - memory mode: no input ack, ignore read
// - input ack only while selected and reading
// - host may gate buffers with input ack
// - request dma when ready to move data
// - host picks direction by read/write strobe
// - hold request until acknowledge, then drop
// - more data: request again after handshake
// - request undriven when not selected
// - host keeps chip selects negated during dma
// - dma words are sixteen bits wide
// - host without dma leaves request unconnected
// - unused dma: host holds acknowledge high
module chbd_dev
  import chbd_pkg::*;
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // pins
  chbd_if.dev bus,
  // card state
  input wire logic i_sel,
  input wire logic i_busy,
  output logic o_peer_active,
  // task file
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic [2:0] o_reg_addr,
  output logic [7:0] o_reg_wdata,
  input wire logic [7:0] i_reg_rdata,
  // data words, pio and dma
  output logic o_wr_word,
  output logic [15:0] o_wr_data,
  output logic o_rd_take,
  input wire logic [15:0] i_rd_data,
  input wire logic i_rd_valid,
  input wire logic i_dma_pend,
  input wire logic i_dma_to_host
);
  typedef enum logic [1:0] {CHBD_D_IDLE, CHBD_D_REQ, CHBD_D_XFER} chbd_dstate_e;

  // ==========================================================
  // pin synchronisers: three stages, accept when last two agree
  logic [24:0] s1_q;
  logic [24:0] s2_q;
  logic [24:0] s3_q;
  logic [24:0] f_q;
  wire [24:0] pins = {bus.cs0_n, bus.cs1_n, bus.iord_n, bus.iowr_n, bus.dmack_n,
                      bus.addr, bus.d, bus.dasp_n};
  wire [24:0] agree = ~(s2_q ^ s3_q);
  wire [24:0] f_d = (s2_q & agree) | (f_q & ~agree);

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      s1_q <= CHBD_DEV_SYNC_RST;
      s2_q <= CHBD_DEV_SYNC_RST;
      s3_q <= CHBD_DEV_SYNC_RST;
      f_q <= CHBD_DEV_SYNC_RST;
    end
    else
    begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
      f_q <= f_d;
    end
  end

  // ==========================================================
  // decode
  wire cs0_n = f_q[24];
  wire iord_n = f_q[22];
  wire iowr_n = f_q[21];
  wire dmack_n = f_q[20];
  wire [2:0] addr = f_q[19:17];
  wire [15:0] din = f_q[16:1];
  wire peer_n = f_q[0];
  logic iord_p_q;
  logic iowr_p_q;
  wire rd_fall = iord_p_q & ~iord_n;
  wire rd_rise = ~iord_p_q & iord_n;
  wire wr_rise = ~iowr_p_q & iowr_n;
  wire is_ide = (bus.mode == CHBD_MODE_IDE);
  wire io_ok = (bus.mode != CHBD_MODE_MEM) & i_sel;
  wire data_hit = io_ok & ~cs0_n & (addr == CHBD_DATA_REG);
  wire tf_hit = io_ok & ~cs0_n & (addr != CHBD_DATA_REG);
  chbd_dstate_e st_q;
  chbd_dstate_e st_d;
  wire in_xfer = (st_q == CHBD_D_XFER);
  wire dma_rd = in_xfer & i_dma_to_host & rd_fall;
  wire dma_wr = in_xfer & ~i_dma_to_host & wr_rise;
  // ready when data waits or space exists
  wire dma_ready = is_ide & i_sel & i_dma_pend & (~i_dma_to_host | i_rd_valid);

  // ==========================================================
  // dma request handshake
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      CHBD_D_IDLE: if (dma_ready) st_d = CHBD_D_REQ;
      CHBD_D_REQ:
      begin
        if (!dmack_n)
          st_d = CHBD_D_XFER;
        else if (!is_ide || !i_sel)
          st_d = CHBD_D_IDLE;
      end
      CHBD_D_XFER: if (dmack_n) st_d = CHBD_D_IDLE;
      default: st_d = CHBD_D_IDLE;
    endcase
  end

  // ==========================================================
  // pin drivers and user strobes
  logic [15:0] dout_q;
  logic [1:0] doe_q;
  logic inpack_n_q;
  logic dmarq_q;
  logic dmarq_oe_q;
  logic dasp_oe_q;
  // own drive echoes through the pin filter for four edges; mask it, one spare
  logic [4:0] own_hist_q;
  wire own_recent = dasp_oe_q | (|own_hist_q);
  // task file uses low lane only
  wire [1:0] lanes_d = tf_hit ? CHBD_LANE_LO : CHBD_LANE_ALL;
  // even byte low, odd byte high
  wire [15:0] word_d = tf_hit ? {8'h00, i_reg_rdata} : i_rd_data;
  wire rd_start = rd_fall & (tf_hit | data_hit | (in_xfer & i_dma_to_host));

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      st_q <= CHBD_D_IDLE;
      iord_p_q <= 1'b1;
      iowr_p_q <= 1'b1;
      dout_q <= 16'h0000;
      doe_q <= 2'h0;
      inpack_n_q <= 1'b1;
      dmarq_q <= 1'b0;
      dmarq_oe_q <= 1'b0;
      dasp_oe_q <= 1'b0;
      own_hist_q <= 5'h00;
      o_peer_active <= 1'b0;
      o_reg_wr <= 1'b0;
      o_reg_rd <= 1'b0;
      o_reg_addr <= 3'h0;
      o_reg_wdata <= 8'h00;
      o_wr_word <= 1'b0;
      o_wr_data <= 16'h0000;
      o_rd_take <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      iord_p_q <= iord_n;
      iowr_p_q <= iowr_n;
      if (rd_start)
      begin
        dout_q <= word_d;
        doe_q <= (in_xfer & ~tf_hit) ? CHBD_LANE_ALL : lanes_d;
      end
      else if (rd_rise || iord_n)
        doe_q <= 2'h0;
      // ack only selected io read in progress
      inpack_n_q <= ~((bus.mode == CHBD_MODE_IO) & i_sel & ~cs0_n & ~iord_n);
      dmarq_q <= (st_d == CHBD_D_REQ);
      dmarq_oe_q <= is_ide & i_sel;
      dasp_oe_q <= is_ide & i_busy;
      own_hist_q <= {own_hist_q[3:0], dasp_oe_q};
      o_peer_active <= is_ide & ~peer_n & ~own_recent;
      o_reg_rd <= rd_fall & tf_hit;
      o_reg_wr <= wr_rise & tf_hit;
      if (wr_rise && tf_hit)
      begin
        o_reg_addr <= addr;
        o_reg_wdata <= din[7:0];
      end
      else if (rd_fall && tf_hit)
        o_reg_addr <= addr;
      // data and dma writes take whole word
      o_wr_word <= (wr_rise & data_hit) | dma_wr;
      if ((wr_rise && data_hit) || dma_wr)
        o_wr_data <= din;
      o_rd_take <= (rd_fall & data_hit) | dma_rd;
    end
  end

  assign bus.dev_d_o = dout_q;
  assign bus.dev_d_oe = doe_q;
  assign bus.inpack_n = inpack_n_q;
  assign bus.dmarq_o = dmarq_q;
  assign bus.dmarq_oe = dmarq_oe_q;
  assign bus.dasp_oe = dasp_oe_q;
endmodule : chbd_dev

// ### core/chbd_host.sv
// host controller end: strobed pio cycles and single-word dma handshake
module chbd_host
  import chbd_pkg::*;
#(
  parameter bit DMA_EN = 1'b1
)
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // pins
  chbd_if.host bus,
  // mode and status
  input wire chbd_mode_e i_mode,
  output logic o_dev_active,
  output logic o_inpack_seen,
  // commands
  input wire logic i_cmd_valid,
  input wire chbd_cmd_e i_cmd_kind,
  input wire logic [2:0] i_cmd_addr,
  input wire logic [15:0] i_cmd_wdata,
  output logic o_cmd_ready,
  output logic o_dma_unsup,
  // read answers
  output logic o_rd_valid,
  output logic [15:0] o_rd_data
);
  typedef enum logic [2:0] {
    CHBD_H_IDLE, CHBD_H_WAIT, CHBD_H_SETUP, CHBD_H_STROBE, CHBD_H_HOLD
  } chbd_hstate_e;

  // ==========================================================
  // pin synchronisers
  logic [18:0] s1_q;
  logic [18:0] s2_q;
  logic [18:0] s3_q;
  logic [18:0] f_q;
  wire [18:0] agree = ~(s2_q ^ s3_q);

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      s1_q <= CHBD_HOST_SYNC_RST;
      s2_q <= CHBD_HOST_SYNC_RST;
      s3_q <= CHBD_HOST_SYNC_RST;
      f_q <= CHBD_HOST_SYNC_RST;
    end
    else
    begin
      s1_q <= {bus.dmarq, bus.inpack_n, bus.d, bus.dasp_n};
      s2_q <= s1_q;
      s3_q <= s2_q;
      f_q <= (s2_q & agree) | (f_q & ~agree);
    end
  end

  wire dmarq = f_q[18];

  // ==========================================================
  // cycle sequencer
  chbd_hstate_e st_q;
  chbd_cmd_e kind_q;
  logic [CHBD_CNT_W-1:0] cnt_q;
  wire is_dma = (kind_q == CHBD_CMD_DMA_RD) | (kind_q == CHBD_CMD_DMA_WR);
  wire is_rd = (kind_q == CHBD_CMD_REG_RD) | (kind_q == CHBD_CMD_DAT_RD) |
               (kind_q == CHBD_CMD_DMA_RD);
  wire cmd_dma = (i_cmd_kind == CHBD_CMD_DMA_RD) | (i_cmd_kind == CHBD_CMD_DMA_WR);
  // no dma support or not ide: refuse
  wire dma_refuse = cmd_dma & (!DMA_EN || i_mode != CHBD_MODE_IDE);
  localparam logic [CHBD_CNT_W-1:0] CNT_SETUP = CHBD_CNT_W'(CHBD_SETUP_CYC - 1);
  localparam logic [CHBD_CNT_W-1:0] CNT_STROBE = CHBD_CNT_W'(CHBD_STROBE_CYC - 1);
  wire take = (st_q == CHBD_H_IDLE) & i_cmd_valid;
  wire setup_done = (cnt_q == CNT_SETUP);
  wire strobe_done = (cnt_q == CNT_STROBE);

  logic [2:0] addr_q;
  logic cs0_n_q;
  logic iord_n_q;
  logic iowr_n_q;
  logic dmack_n_q;
  logic [15:0] d_q;
  logic [1:0] doe_q;
  chbd_mode_e mode_q;

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      st_q <= CHBD_H_IDLE;
      kind_q <= CHBD_CMD_REG_RD;
      cnt_q <= '0;
      addr_q <= 3'h0;
      cs0_n_q <= 1'b1;
      iord_n_q <= 1'b1;
      iowr_n_q <= 1'b1;
      dmack_n_q <= 1'b1;
      d_q <= 16'h0000;
      doe_q <= 2'h0;
      mode_q <= CHBD_MODE_MEM;
      o_cmd_ready <= 1'b0;
      o_dma_unsup <= 1'b0;
      o_rd_valid <= 1'b0;
      o_rd_data <= 16'h0000;
      o_dev_active <= 1'b0;
      o_inpack_seen <= 1'b0;
    end
    else
    begin
      mode_q <= i_mode;
      o_dev_active <= ~f_q[0];
      o_inpack_seen <= ~f_q[17];
      o_dma_unsup <= take & dma_refuse;
      o_rd_valid <= 1'b0;
      cnt_q <= cnt_q + CHBD_CNT_W'(1);
      case (st_q)
        CHBD_H_IDLE:
        begin
          cnt_q <= '0;
          if (take && !dma_refuse)
          begin
            kind_q <= i_cmd_kind;
            addr_q <= cmd_dma ? CHBD_DATA_REG : i_cmd_addr;
            d_q <= i_cmd_wdata;
            // chip selects stay negated for dma
            cs0_n_q <= cmd_dma;
            // register write on low lane only
            if (i_cmd_kind == CHBD_CMD_REG_WR)
              doe_q <= CHBD_LANE_LO;
            else if (i_cmd_kind == CHBD_CMD_DAT_WR || i_cmd_kind == CHBD_CMD_DMA_WR)
              doe_q <= CHBD_LANE_ALL;
            st_q <= cmd_dma ? CHBD_H_WAIT : CHBD_H_SETUP;
          end
        end
        CHBD_H_WAIT:
        begin
          cnt_q <= '0;
          if (dmarq)
          begin
            dmack_n_q <= 1'b0;
            st_q <= CHBD_H_SETUP;
          end
        end
        CHBD_H_SETUP:
        begin
          if (setup_done)
          begin
            cnt_q <= '0;
            iord_n_q <= ~is_rd;
            iowr_n_q <= is_rd;
            st_q <= CHBD_H_STROBE;
          end
        end
        CHBD_H_STROBE:
        begin
          if (strobe_done)
          begin
            cnt_q <= '0;
            iord_n_q <= 1'b1;
            iowr_n_q <= 1'b1;
            o_rd_valid <= is_rd;
            // task file reads carry low byte only
            if (is_rd)
              o_rd_data <= (kind_q == CHBD_CMD_REG_RD) ? {8'h00, f_q[8:1]} : f_q[16:1];
            st_q <= CHBD_H_HOLD;
          end
        end
        CHBD_H_HOLD:
        begin
          if (setup_done)
          begin
            cs0_n_q <= 1'b1;
            dmack_n_q <= 1'b1;
            doe_q <= 2'h0;
            st_q <= CHBD_H_IDLE;
          end
        end
        default: st_q <= CHBD_H_IDLE;
      endcase
      o_cmd_ready <= (st_q == CHBD_H_IDLE) ? ~i_cmd_valid : (st_q == CHBD_H_HOLD) & setup_done;
    end
  end

  assign bus.mode = mode_q;
  assign bus.addr = addr_q;
  assign bus.cs0_n = cs0_n_q;
  assign bus.cs1_n = 1'b1;
  assign bus.iord_n = iord_n_q;
  assign bus.iowr_n = iowr_n_q;
  assign bus.dmack_n = is_dma ? dmack_n_q : 1'b1;
  assign bus.host_d_o = d_q;
  assign bus.host_d_oe = doe_q;
endmodule : chbd_host

// ### bench/chbd_monitor.sv
// concurrent checks on the pins between card and host ends
module chbd_monitor
  import chbd_pkg::*;
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // card select level
  input wire logic sel,
  // host driven pins
  input wire chbd_mode_e mode,
  input wire logic [2:0] addr,
  input wire logic cs0_n,
  input wire logic cs1_n,
  input wire logic iord_n,
  input wire logic iowr_n,
  input wire logic dmack_n,
  input wire logic [1:0] host_d_oe,
  // card driven pins
  input wire logic [1:0] dev_d_oe,
  input wire logic inpack_n,
  input wire logic dmarq,
  input wire logic dmarq_oe
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rstn);
  // ==========
  // sequences
  sequence s_read_start;
    $fell(iord_n) && !cs0_n && mode != CHBD_MODE_MEM && sel;
  endsequence
  sequence s_dev_drives;
    ##[1:8] dev_d_oe != 2'h0;
  endsequence
  // ==========
  // properties
  property p_read_answer;
    s_read_start |-> s_dev_drives;
  endproperty
  property p_inpack_start;
    $fell(inpack_n) |-> !iord_n && !cs0_n && mode == CHBD_MODE_IO && sel;
  endproperty
  // mode reaches the card unfiltered but selects and strobes pass the pin filter, so allow them to settle first
  property p_mem_quiet;
    mode == CHBD_MODE_MEM [*8] |-> inpack_n && dev_d_oe == 2'h0;
  endproperty
  property p_reg_lane;
    !cs0_n && addr != CHBD_DATA_REG && (dev_d_oe | host_d_oe) != 2'h0
      |-> (dev_d_oe | host_d_oe) == CHBD_LANE_LO;
  endproperty
  property p_data_lane;
    !cs0_n && addr == CHBD_DATA_REG && (dev_d_oe | host_d_oe) != 2'h0
      |-> (dev_d_oe | host_d_oe) == CHBD_LANE_ALL;
  endproperty
  property p_dma_word;
    !dmack_n && (dev_d_oe | host_d_oe) != 2'h0 |-> (dev_d_oe | host_d_oe) == CHBD_LANE_ALL;
  endproperty
  property p_dma_cs;
    !dmack_n |-> cs0_n && cs1_n && (iord_n || iowr_n);
  endproperty
  property p_req_hold;
    $fell(dmarq) && dmarq_oe |-> !dmack_n;
  endproperty
  property p_req_again;
    $rose(dmarq) |-> dmack_n;
  endproperty
  property p_req_drop;
    $fell(dmack_n) |-> ##8 !dmarq;
  endproperty
  property p_req_oe;
    mode != CHBD_MODE_IDE [*8] |-> !dmarq_oe;
  endproperty
  property p_ack_idle;
    mode != CHBD_MODE_IDE |-> dmack_n;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
  a_inpack_start: assert property (p_inpack_start) else $error("stray input ack");
  a_mem_quiet: assert property (p_mem_quiet) else $error("card active in memory mode");
  a_reg_lane: assert property (p_reg_lane) else $error("task file off low lane");
  a_data_lane: assert property (p_data_lane) else $error("data not full word");
  a_dma_word: assert property (p_dma_word) else $error("dma word not 16 bits");
  a_dma_cs: assert property (p_dma_cs) else $error("select or strobes wrong in dma");
  a_req_hold: assert property (p_req_hold) else $error("request dropped before ack");
  a_req_again: assert property (p_req_again) else $error("request raised during ack");
  a_req_drop: assert property (p_req_drop) else $error("request kept after ack");
  a_req_oe: assert property (p_req_oe) else $error("request driven outside ide");
  a_ack_idle: assert property (p_ack_idle) else $error("ack low outside ide");
endmodule : chbd_monitor

// ### bench/card_host_bus_dma_handshake_tb.sv
// bench joining card and host ends through the pin bundle
module card_host_bus_dma_handshake_tb
  import chbd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // stimulus and observation
  logic i_sys_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic sel = 1'b1, busy = 1'b0, rd_vld = 1'b1, dma_pend = 1'b0, dma_to_host = 1'b0;
  logic [7:0] reg_rdata = 8'h00;
  logic [15:0] rd_data = 16'h0000, cmd_wdata = 16'h0000;
  logic [2:0] cmd_addr = 3'h0;
  logic cmd_valid = 1'b0;
  chbd_cmd_e cmd_kind = CHBD_CMD_REG_RD;
  chbd_mode_e mode_in = CHBD_MODE_MEM;
  logic peer_active, reg_wr, reg_rd, wr_word, rd_take, dev_active, inpack_seen;
  logic cmd_ready, dma_unsup, h_rd_valid;
  logic [2:0] reg_addr, got_addr;
  logic [7:0] reg_wdata, got_byte;
  logic [15:0] wr_data, h_rd_data, got_word;
  int n_ev = 0, n_unsup = 0, err_total = 0, num_checks = 0;
  int n_take = 0, n_regrd = 0, n_peer = 0;
  always #10 i_sys_clk = ~i_sys_clk;
  chbd_if bus ();
  chbd_dev chbd_dev_i (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .bus(bus.dev), .i_sel(sel),
    .i_busy(busy), .o_peer_active(peer_active), .o_reg_wr(reg_wr), .o_reg_rd(reg_rd),
    .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata), .i_reg_rdata(reg_rdata),
    .o_wr_word(wr_word), .o_wr_data(wr_data), .o_rd_take(rd_take), .i_rd_data(rd_data),
    .i_rd_valid(rd_vld), .i_dma_pend(dma_pend), .i_dma_to_host(dma_to_host));
  chbd_host #(.DMA_EN(1'b1)) chbd_host_i (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
    .bus(bus.host), .i_mode(mode_in), .o_dev_active(dev_active), .o_inpack_seen(inpack_seen),
    .i_cmd_valid(cmd_valid), .i_cmd_kind(cmd_kind), .i_cmd_addr(cmd_addr),
    .i_cmd_wdata(cmd_wdata), .o_cmd_ready(cmd_ready), .o_dma_unsup(dma_unsup),
    .o_rd_valid(h_rd_valid), .o_rd_data(h_rd_data));
  chbd_monitor chbd_monitor_i (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .sel(sel), .mode(bus.mode),
    .addr(bus.addr), .cs0_n(bus.cs0_n), .cs1_n(bus.cs1_n), .iord_n(bus.iord_n),
    .iowr_n(bus.iowr_n), .dmack_n(bus.dmack_n), .host_d_oe(bus.host_d_oe),
    .dev_d_oe(bus.dev_d_oe), .inpack_n(bus.inpack_n), .dmarq(bus.dmarq),
    .dmarq_oe(bus.dmarq_oe));
  // card side pulses only last one cycle, so latch them here
  always @(posedge i_sys_clk)
  begin
    if (reg_wr === 1'b1)
    begin
      got_addr <= reg_addr;
      got_byte <= reg_wdata;
      n_ev <= n_ev + 1;
    end
    if (wr_word === 1'b1)
    begin
      got_word <= wr_data;
      n_ev <= n_ev + 1;
    end
    if (dma_unsup === 1'b1)
      n_unsup <= n_unsup + 1;
    if (rd_take === 1'b1)
      n_take <= n_take + 1;
    if (reg_rd === 1'b1)
      n_regrd <= n_regrd + 1;
    if (peer_active === 1'b1)
      n_peer <= n_peer + 1;
  end
  // ==========
  // tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop
  task automatic give_up();
    err_total++;
    $display("BAD %0t wait ran out", $time);
    report_and_stop();
  endtask : give_up
  task automatic run_cmd(input chbd_cmd_e k, input logic [2:0] a, input logic [15:0] w);
    int i;
    for (i = 0; i < 100 && cmd_ready !== 1'b1; i++) @(negedge i_sys_clk);
    if (i == 100) give_up();
    cmd_kind = k;
    cmd_addr = a;
    cmd_wdata = w;
    cmd_valid = 1'b1;
    @(negedge i_sys_clk);
    cmd_valid = 1'b0;
    // ready may lag a cycle behind the take
    repeat (3) @(negedge i_sys_clk);
  endtask : run_cmd
  task automatic read_cmd(input chbd_cmd_e k, input logic [2:0] a, output logic [15:0] d);
    int i;
    run_cmd(k, a, 16'h0000);
    for (i = 0; i < 300 && h_rd_valid !== 1'b1; i++)
    begin
      @(posedge i_sys_clk);
      #1;
    end
    if (i == 300) give_up();
    d = h_rd_data;
    // back to the falling edge so the caller's stimulus keeps its timing
    @(negedge i_sys_clk);
  endtask : read_cmd
  task automatic write_cmd(input chbd_cmd_e k, input logic [2:0] a, input logic [15:0] w);
    int i;
    int n0;
    n0 = n_ev;
    run_cmd(k, a, w);
    for (i = 0; i < 300 && n_ev == n0; i++) @(negedge i_sys_clk);
    if (i == 300) give_up();
  endtask : write_cmd
  // ==========
  // sequence of tests
  initial
  begin
    logic [15:0] v;
    int n0;
    repeat (4) @(negedge i_sys_clk);
    i_rstn = 1'b1;
    mode_in = CHBD_MODE_IDE;
    repeat (10) @(negedge i_sys_clk);
    write_cmd(CHBD_CMD_REG_WR, 3'h3, 16'h5AA5);
    check(got_addr, 16'h0003);
    check(got_byte, 16'h00A5);
    reg_rdata = 8'h3C;
    read_cmd(CHBD_CMD_REG_RD, 3'h2, v);
    check(v, 16'h003C);
    write_cmd(CHBD_CMD_DAT_WR, CHBD_DATA_REG, 16'h1234);
    check(got_word, 16'h1234);
    rd_data = 16'hBEEF;
    read_cmd(CHBD_CMD_DAT_RD, CHBD_DATA_REG, v);
    check(v, 16'hBEEF);
    busy = 1'b1;
    repeat (8) @(negedge i_sys_clk);
    check(dev_active, 16'h0001);
    check(bus.dasp_n, 16'h0000);
    check(peer_active, 16'h0000);
    dma_pend = 1'b1;
    dma_to_host = 1'b1;
    rd_data = 16'hCAFE;
    read_cmd(CHBD_CMD_DMA_RD, 3'h0, v);
    check(v, 16'hCAFE);
    rd_data = 16'h0F0F;
    read_cmd(CHBD_CMD_DMA_RD, 3'h0, v);
    check(v, 16'h0F0F);
    dma_to_host = 1'b0;
    write_cmd(CHBD_CMD_DMA_WR, 3'h0, 16'h55AA);
    check(got_word, 16'h55AA);
    // own activity ends; its lagging echo must not look like a peer
    busy = 1'b0;
    repeat (10) @(negedge i_sys_clk);
    check(dev_active, 16'h0000);
    mode_in = CHBD_MODE_IO;
    repeat (10) @(negedge i_sys_clk);
    reg_rdata = 8'h81;
    read_cmd(CHBD_CMD_REG_RD, 3'h1, v);
    check(v, 16'h0081);
    check(inpack_seen, 16'h0001);
    mode_in = CHBD_MODE_MEM;
    repeat (10) @(negedge i_sys_clk);
    read_cmd(CHBD_CMD_REG_RD, 3'h1, v);
    check(v, 16'h00FF);
    check(inpack_seen, 16'h0000);
    n0 = n_unsup;
    run_cmd(CHBD_CMD_DMA_RD, 3'h0, 16'h0000);
    check(16'(n_unsup - n0), 16'h0001);
    // deselected card must not answer an io read
    mode_in = CHBD_MODE_IO;
    sel = 1'b0;
    repeat (10) @(negedge i_sys_clk);
    read_cmd(CHBD_CMD_REG_RD, 3'h1, v);
    check(v, 16'h00FF);
    check(inpack_seen, 16'h0000);
    mode_in = CHBD_MODE_IDE;
    repeat (10) @(negedge i_sys_clk);
    check(bus.dmarq_oe, 16'h0000);
    check(bus.dmarq, 16'h0000);
    check(16'(n_regrd), 16'h0002);
    check(16'(n_take), 16'h0003);
    check(16'(n_peer), 16'h0000);
    report_and_stop();
  end
endmodule : card_host_bus_dma_handshake_tb
